/* File: sc2_pkg.sv */
// Package for the second serial control register block
package sc2_pkg;
  localparam logic [2:0] SC2_ADDR_CTRL2  = 3'h0;
  localparam logic [2:0] SC2_ADDR_CTRL1  = 3'h1;
  localparam logic [2:0] SC2_ADDR_FLAGS  = 3'h2;
  localparam logic [2:0] SC2_ADDR_STAT   = 3'h3;
  localparam logic [2:0] SC2_ADDR_MASK   = 3'h4;
  localparam logic [2:0] SC2_ADDR_DATA   = 3'h5;
  localparam int SC2_BIT_TX_EMPTY_IE = 7;
  localparam int SC2_BIT_TX_DONE_IE  = 6;
  localparam int SC2_BIT_RX_FULL_IE  = 5;
  localparam int SC2_BIT_IDLE_IE     = 4;
  localparam int SC2_BIT_TX_ON       = 3;
  localparam int SC2_BIT_RX_ON       = 2;
  localparam int SC2_BIT_RX_STANDBY  = 1;
  localparam int SC2_BIT_BREAK_Q     = 0;
  localparam int SC2_BIT_LOOP_SEL    = 0;
  localparam int SC2_BIT_SRC_SEL     = 1;
  localparam int SC2_BIT_LINE_DIR    = 2;
  localparam logic [7:0] SC2_CTRL2_RST = 8'h00;
  localparam logic [7:0] SC2_CTRL1_RST = 8'h00;
  localparam logic [7:0] SC2_MASK_RST  = 8'h00;
  localparam int SC2_CLK_HZ  = 100_000_000;
  localparam int SC2_BAUD    = 115_200;
  localparam int SC2_BIT_CYC = SC2_CLK_HZ / SC2_BAUD;
  localparam int SC2_FRAME_BITS = 10;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sc2_bus_type;

  typedef struct packed {
    logic o;
    logic oe;
  } sc2_pin_type;
endpackage : sc2_pkg

/* File: sc2_tx_shifter.sv */
// Serial shifter: sends one data, idle or break frame at a time
`timescale 1ns/100ps
module sc2_tx_shifter #(
  parameter int BIT_CYC    = 868,
  parameter int FRAME_BITS = 10
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_start,
  input  wire logic [9:0] i_frame,
  output logic            o_busy,
  output logic            o_line
);
  logic [9:0]  shift_r;
  logic [15:0] cyc_r;
  logic [3:0]  bits_r;
  logic        busy_r;
  wire         bit_end = (cyc_r == 16'(BIT_CYC - 1));
  wire         last    = (bits_r == 4'(FRAME_BITS - 1));

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_r <= 10'h3FF;
      cyc_r   <= 16'h0000;
      bits_r  <= 4'h0;
      busy_r  <= 1'b0;
    end else if (!busy_r) begin
      if (i_start) begin
        shift_r <= i_frame;
        busy_r  <= 1'b1;
      end
      cyc_r  <= 16'h0000;
      bits_r <= 4'h0;
    end else if (bit_end) begin
      cyc_r   <= 16'h0000;
      shift_r <= {1'b1, shift_r[9:1]};
      bits_r  <= bits_r + 4'h1;
      if (last) begin
        busy_r <= 1'b0;
      end
    end else begin
      cyc_r <= cyc_r + 16'h0001;
    end
  end

  assign o_busy = busy_r;
  assign o_line = busy_r ? shift_r[0] : 1'b1;
endmodule : sc2_tx_shifter

/* File: sc2_ctrl.sv */
// Second serial control register with transmitter pin ownership and interrupts
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
import sc2_pkg::*;
module sc2_ctrl #(
  parameter int BIT_CYC = SC2_BIT_CYC
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_arst_n,
  input  wire sc2_pkg::sc2_bus_type i_bus,
  output logic [7:0]             o_rdata,
  input  wire logic              i_rx_full_flag,
  input  wire logic              i_line_idle_flag,
  input  wire logic              i_txd_pin,
  input  wire logic              i_rxd_pin,
  output logic                   o_txd_out,
  output logic                   o_txd_oe,
  output logic                   o_rx_line,
  output logic                   o_rx_pin_used,
  output logic                   o_irq_req,
  output logic                   o_irq
);
  import sc2_pkg::*;

  logic [7:0] ctrl2_r;
  logic [7:0] ctrl1_r;
  logic [7:0] mask_r;
  logic [3:0] stat_r;
  logic [7:0] buf_r;
  logic       buf_full_r;
  logic       idle_q_r;
  logic       brk_q_r;
  logic       tx_empty_r;
  logic       tx_done_r;
  logic       own_r;
  logic [7:0] rdata_r;
  logic       irq_req_r;
  logic       irq_r;
  logic       txd_r;
  logic       oe_r;
  logic       rxl_r;
  logic       rxu_r;
  logic       txs1_r;
  logic       txs2_r;
  logic       rxs1_r;
  logic       rxs2_r;
  logic       sh_busy;
  logic       sh_line;

  wire wr_c2   = i_bus.wr && (i_bus.addr == SC2_ADDR_CTRL2);
  wire wr_c1   = i_bus.wr && (i_bus.addr == SC2_ADDR_CTRL1);
  wire wr_stat = i_bus.wr && (i_bus.addr == SC2_ADDR_STAT);
  wire wr_mask = i_bus.wr && (i_bus.addr == SC2_ADDR_MASK);
  wire wr_data = i_bus.wr && (i_bus.addr == SC2_ADDR_DATA);
  wire tx_on   = ctrl2_r[SC2_BIT_TX_ON];
  wire new_on  = i_bus.wdata[SC2_BIT_TX_ON];
  wire brk_new = i_bus.wdata[SC2_BIT_BREAK_Q];
  // Off-to-on edge of the enable queues an idle frame
  wire te_rise = wr_c2 && new_on && !tx_on;
  wire brk_rel = wr_c2 && !brk_new && ctrl2_r[SC2_BIT_BREAK_Q];
  wire single  = ctrl1_r[SC2_BIT_LOOP_SEL] && ctrl1_r[SC2_BIT_SRC_SEL];
  wire loop_on = ctrl1_r[SC2_BIT_LOOP_SEL];
  // Idle and break frames take priority over data so their order is kept
  wire go_idle = !sh_busy && idle_q_r;
  wire go_brk  = !sh_busy && !idle_q_r && brk_q_r;
  // Data buffered while enabled still leaves after the enable clears, or the pin is never freed
  wire go_data = !sh_busy && !idle_q_r && !brk_q_r && buf_full_r;
  wire start   = go_idle || go_brk || go_data;
  wire [9:0] frame = go_idle ? 10'h3FF : (go_brk ? 10'h000 : {1'b1, buf_r, 1'b0});
  wire pending = sh_busy || idle_q_r || brk_q_r || buf_full_r;
  wire own_nxt = tx_on || (own_r && pending);
  wire [3:0] ev = {tx_empty_r, tx_done_r, i_rx_full_flag, i_line_idle_flag};
  wire [3:0] en = ctrl2_r[7:4];
  wire req_nxt = |(ev & en);
  wire [3:0] stat_nxt = (stat_r & ~(wr_stat ? i_bus.wdata[3:0] : 4'h0)) | (ev & en);
  wire drive   = own_r && (!single || ctrl1_r[SC2_BIT_LINE_DIR]);
  wire [7:0] rd_mux = (i_bus.addr == SC2_ADDR_CTRL2) ? ctrl2_r :
                      (i_bus.addr == SC2_ADDR_CTRL1) ? ctrl1_r :
                      (i_bus.addr == SC2_ADDR_FLAGS) ? {4'h0, ev} :
                      (i_bus.addr == SC2_ADDR_STAT)  ? {4'h0, stat_r} :
                      (i_bus.addr == SC2_ADDR_MASK)  ? mask_r : 8'h00;

  sc2_tx_shifter #(
    .BIT_CYC    (BIT_CYC),
    .FRAME_BITS (SC2_FRAME_BITS)
  ) u_shift (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_start   (start),
    .i_frame   (frame),
    .o_busy    (sh_busy),
    .o_line    (sh_line)
  );

  // Register file, writable at any time
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl2_r <= SC2_CTRL2_RST;
      ctrl1_r <= SC2_CTRL1_RST;
      mask_r  <= SC2_MASK_RST;
      rdata_r <= 8'h00;
    end else begin
      if (wr_c2) ctrl2_r <= i_bus.wdata;
      if (wr_c1) ctrl1_r <= i_bus.wdata;
      if (wr_mask) mask_r <= i_bus.wdata;
      rdata_r <= i_bus.rd ? rd_mux : 8'h00;
    end
  end

  // Transmit queue state
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      buf_r      <= 8'h00;
      buf_full_r <= 1'b0;
      idle_q_r   <= 1'b0;
      brk_q_r    <= 1'b0;
      tx_empty_r <= 1'b1;
      tx_done_r  <= 1'b1;
    end else begin
      if (wr_data && tx_on) begin
        buf_r      <= i_bus.wdata;
        buf_full_r <= 1'b1;
        tx_empty_r <= 1'b0;
      end else if (go_data) begin
        buf_full_r <= 1'b0;
        tx_empty_r <= 1'b1;
      end
      if (te_rise) idle_q_r <= 1'b1;
      else if (go_idle) idle_q_r <= 1'b0;
      if (brk_rel) brk_q_r <= 1'b1;
      else if (go_brk) brk_q_r <= 1'b0;
      if (te_rise || brk_rel || (wr_data && tx_on)) tx_done_r <= 1'b0;
      else if (!pending && !start) tx_done_r <= 1'b1;
    end
  end

  // Sticky status: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_r    <= 4'h0;
      irq_req_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      stat_r    <= stat_nxt;
      irq_req_r <= req_nxt;
      irq_r     <= |(stat_nxt & mask_r[3:0]);
    end
  end

  // Pins; inputs pass two flops before use
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      own_r  <= 1'b0;
      txd_r  <= 1'b1;
      oe_r   <= 1'b0;
      rxl_r  <= 1'b1;
      rxu_r  <= 1'b0;
      txs1_r <= 1'b1;
      txs2_r <= 1'b1;
      rxs1_r <= 1'b1;
      rxs2_r <= 1'b1;
    end else begin
      txs1_r <= i_txd_pin;
      txs2_r <= txs1_r;
      rxs1_r <= i_rxd_pin;
      rxs2_r <= rxs1_r;
      own_r  <= own_nxt;
      txd_r  <= sh_line;
      oe_r   <= drive;
      // Loopback hears the shifter; single wire hears the shared pin, or the shifter while driving it
      rxl_r  <= !loop_on ? rxs2_r : (single ? (drive ? sh_line : txs2_r) : sh_line);
      rxu_r  <= ctrl2_r[SC2_BIT_RX_ON] && !loop_on;
    end
  end

  assign o_rdata       = rdata_r;
  assign o_txd_out     = txd_r;
  assign o_txd_oe      = oe_r;
  assign o_rx_line     = rxl_r;
  assign o_rx_pin_used = rxu_r;
  assign o_irq_req     = irq_req_r;
  assign o_irq         = irq_r;
endmodule : sc2_ctrl

/* File: sc2_ctrl_props.sv */
// Property checker for the second serial control register
`timescale 1ns/100ps
module sc2_ctrl_props
  import sc2_pkg::*;
#(
  parameter int BIT_CYC = 4
) (
  input wire logic                 i_ref_clk,
  input wire logic                 i_arst_n,
  input wire sc2_pkg::sc2_bus_type i_bus,
  input wire logic [7:0]           o_rdata,
  input wire logic                 i_rx_full_flag,
  input wire logic                 i_line_idle_flag,
  input wire logic                 o_txd_out,
  input wire logic                 o_txd_oe,
  input wire logic                 o_irq_req,
  input wire logic                 o_irq
);
  logic [7:0] c2_r;
  logic [2:0] c1_r;
  logic [3:0] mk_r;
  wire        c2_wr = i_bus.wr && i_bus.addr == SC2_ADDR_CTRL2;
  wire        one_wire = c1_r[1:0] == 2'b11;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      c2_r <= 8'h00;
      c1_r <= 3'h0;
      mk_r <= 4'h0;
    end else if (i_bus.wr) begin
      if (i_bus.addr == SC2_ADDR_CTRL2) c2_r <= i_bus.wdata;
      if (i_bus.addr == SC2_ADDR_CTRL1) c1_r <= i_bus.wdata[2:0];
      if (i_bus.addr == SC2_ADDR_MASK) mk_r <= i_bus.wdata[3:0];
    end
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence start_edge;
    $fell(o_txd_out) && o_txd_oe;
  endsequence
  // Repetition count matches the shortened BIT_CYC of 4 used in simulation
  sequence start_bit;
    (!o_txd_out)[*4];
  endsequence
  rd_quiet_a: assert property (!i_bus.rd |=> o_rdata == 8'h00)
    else $error("read data not zero");
  rd_ctrl_a: assert property (i_bus.rd && i_bus.addr == SC2_ADDR_CTRL2 |=> o_rdata == c2_r)
    else $error("control readback wrong");
  rx_irq_a: assert property (c2_r[5] && i_rx_full_flag |=> o_irq_req)
    else $error("receive request missing");
  idle_irq_a: assert property (c2_r[4] && i_line_idle_flag |=> o_irq_req)
    else $error("idle request missing");
  irq_quiet_a: assert property (c2_r[7:4] == 4'h0 |=> !o_irq_req)
    else $error("request without enable");
  mask_quiet_a: assert property (mk_r == 4'h0 |=> !o_irq)
    else $error("interrupt while masked");
  oe_takes_a: assert property (c2_wr && i_bus.wdata[3] && !one_wire |-> ##[1:3] o_txd_oe)
    else $error("pin not taken");
  oe_release_a: assert property ($fell(o_txd_oe) |-> !c2_r[3] || one_wire)
    else $error("pin released while enabled");
  start_bit_a: assert property (start_edge |-> start_bit)
    else $error("start bit too short");
endmodule : sc2_ctrl_props

bind sc2_ctrl sc2_ctrl_props #(.BIT_CYC(BIT_CYC)) chk_u (.i_ref_clk(i_ref_clk),
  .i_arst_n(i_arst_n), .i_bus(i_bus), .o_rdata(o_rdata), .i_rx_full_flag(i_rx_full_flag),
  .i_line_idle_flag(i_line_idle_flag), .o_txd_out(o_txd_out), .o_txd_oe(o_txd_oe),
  .o_irq_req(o_irq_req), .o_irq(o_irq));

/* File: sc2_far.sv */
// Far-end receiver on the serial line
`timescale 1ns/100ps
module sc2_far #(
  parameter int BIT_CYC = 4
) (
  input  wire logic i_ref_clk,
  input  wire logic i_line,
  output logic      o_rxd,
  output logic [7:0] o_byte,
  output int        o_count
);
  initial begin
    // Far transmit held low so a wrong receive-pin choice shows up
    o_rxd = 1'b0;
    o_byte = 8'h00;
    o_count = 0;
    forever begin
      @(negedge i_line);
      // Sample mid-bit so edge races cannot matter
      repeat (BIT_CYC / 2) @(posedge i_ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge i_ref_clk);
        o_byte[i] = i_line;
      end
      repeat (BIT_CYC) @(posedge i_ref_clk);
      if (i_line) o_count++;
    end
  end
endmodule : sc2_far

/* File: sc2_ctrl_test.sv */
// Self-checking bench for the second serial control register
`timescale 1ns/100ps
module sc2_ctrl_test;
  import sc2_pkg::*;
  logic clk = 0, rst_n = 0, rxf = 0, idl = 0;
  sc2_bus_type bus = '0;
  logic [7:0] rdat, v;
  logic out, oe, line, rxd, irq_req, irq, rxl, rxu;
  int n_fail = 0, checks = 0, cnt;
  // Pull-up holds the released pin high
  assign line = oe ? out : 1'b1;
  sc2_ctrl #(.BIT_CYC(4)) dut_u (.i_ref_clk(clk), .i_arst_n(rst_n), .i_bus(bus),
    .o_rdata(rdat), .i_rx_full_flag(rxf), .i_line_idle_flag(idl), .i_txd_pin(line),
    .i_rxd_pin(rxd), .o_txd_out(out), .o_txd_oe(oe), .o_rx_line(rxl), .o_rx_pin_used(rxu),
    .o_irq_req(irq_req), .o_irq(irq));
  sc2_far #(.BIT_CYC(4)) far_u (.i_ref_clk(clk), .i_line(line), .o_rxd(rxd),
    .o_byte(v), .o_count(cnt));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask : wr
  task automatic rdc(logic [2:0] a, logic [7:0] e, string n);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk(n, e, rdat);
  endtask : rdc
  task automatic idle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic wait_oe(logic e);
    for (int i = 0; i < 199 && oe !== e; i++) idle(1);
    chk("oe", {7'h0, e}, {7'h0, oe});
    if (oe !== e) give_verdict();
  endtask : wait_oe
  task automatic t_regs;
    rdc(SC2_ADDR_CTRL2, 8'h00, "ctrl2 reset");
    rdc(SC2_ADDR_FLAGS, 8'h0C, "flags reset");
    wr(SC2_ADDR_CTRL2, 8'hF4);
    rdc(SC2_ADDR_CTRL2, 8'hF4, "ctrl2");
    chk("rx pin used", 8'h01, {7'h0, rxu});
    chk("rx line pin", 8'h00, {7'h0, rxl});
    rdc(3'h7, 8'h00, "unmapped");
    wr(SC2_ADDR_CTRL2, 8'h00);
  endtask : t_regs
  task automatic t_irq;
    @(posedge clk) {rxf, idl} <= 2'b11;
    for (int k = 4; k < 8; k++) begin
      wr(SC2_ADDR_CTRL2, 8'h01 << k);
      idle(2);
      chk("irq_req", 8'h01, {7'h0, irq_req});
    end
    @(posedge clk) {rxf, idl} <= 2'b00;
    wr(SC2_ADDR_CTRL2, 8'h30);
    idle(2);
    chk("irq_req off", 8'h00, {7'h0, irq_req});
    wr(SC2_ADDR_MASK, 8'h03);
    idle(2);
    chk("irq", 8'h01, {7'h0, irq});
    wr(SC2_ADDR_STAT, 8'h03);
    idle(2);
    chk("irq clear", 8'h00, {7'h0, irq});
    wr(SC2_ADDR_CTRL2, 8'h00);
  endtask : t_irq
  task automatic t_tx;
    wr(SC2_ADDR_CTRL2, 8'h08);
    wait_oe(1'b1);
    wr(SC2_ADDR_DATA, 8'h55);
    rdc(SC2_ADDR_FLAGS, 8'h00, "flags busy");
    wr(SC2_ADDR_CTRL2, 8'h00);
    idle(8);
    chk("oe held", 8'h01, {7'h0, oe});
    wait_oe(1'b0);
    chk("far byte", 8'h55, v);
    chk("far count", 8'h01, 8'(cnt));
    rdc(SC2_ADDR_FLAGS, 8'h0C, "flags done");
  endtask : t_tx
  task automatic t_wire;
    wr(SC2_ADDR_CTRL1, 8'h03);
    wr(SC2_ADDR_CTRL2, 8'h0C);
    idle(4);
    chk("oe listen", 8'h00, {7'h0, oe});
    chk("rx pin loop", 8'h00, {7'h0, rxu});
    chk("rx line wire", 8'h01, {7'h0, rxl});
    wr(SC2_ADDR_CTRL1, 8'h07);
    wait_oe(1'b1);
    wr(SC2_ADDR_CTRL2, 8'h00);
    wait_oe(1'b0);
  endtask : t_wire
  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial forever #5 clk = ~clk;
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_irq();
    t_tx();
    t_wire();
    give_verdict();
  end
endmodule : sc2_ctrl_test
